// [bench/lsr_access_props.sv]
// Purpose: Port assertions for the legacy socket register access block
// Assumes: Default counts of two sockets, two I/O and five memory windows
// Notes: Requests in a bus reset cycle are left out of the antecedents except a_io_write_quiet
`timescale 1ns/1ps
module lsr_access_props
    import lsr_pkg::*;
(
    // Watched ports
    input wire logic clk_i, reset_n_i, pci_bus_reset_n_i, io_valid_i, io_write_i,
    input wire logic mem_valid_i, mem_write_i, rd_valid_o, sock_ctl_valid_o,
    input wire logic sock_ctl_write_o, sock_ctl_func_o,
    input wire logic [15:0] io_base_i, io_addr_i,
    input wire logic [19:0] sock_a_base_i, sock_b_base_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [10:0] sock_ctl_addr_o,
    input wire logic [23:0] host_mem_addr_i,
    input wire logic [3:0] io_win_hit_o,
    input wire logic [31:0] card_io_addr_o,
    input wire logic [9:0] mem_win_hit_o,
    input wire logic [51:0] card_mem_addr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic io_sel;
    logic mem_hit;
    assign io_sel = io_addr_i == io_base_i || io_addr_i == io_base_i + LSR_DATA_PORT_OFS;
    assign mem_hit = mem_valid_i && !io_valid_i && pci_bus_reset_n_i &&
        (mem_addr_i[31:12] == sock_a_base_i || mem_addr_i[31:12] == sock_b_base_i);
    sequence s_io_read;
        pci_bus_reset_n_i && io_valid_i && !io_write_i && io_sel;
    endsequence
    sequence s_alias_read;
        mem_hit && !mem_write_i && mem_addr_i[11:0] >= LSR_ALIAS_FIRST &&
            mem_addr_i[11:0] <= LSR_ALIAS_LAST;
    endsequence
    sequence s_ctl_fwd;
        sock_ctl_valid_o && sock_ctl_addr_o == $past(mem_addr_i[10:0]) &&
            sock_ctl_write_o == $past(mem_write_i);
    endsequence
    a_io_read_answer: assert property (s_io_read |=> rd_valid_o)
        else $error("io read gave no answer");
    a_io_write_quiet: assert property (io_valid_i && io_write_i && io_sel |=> !rd_valid_o)
        else $error("io write gave a read answer");
    a_rd_has_cause: assert property (rd_valid_o |-> $past(io_valid_i || mem_valid_i))
        else $error("read answer without request");
    a_alias_answer: assert property (s_alias_read |=> rd_valid_o)
        else $error("alias read gave no answer");
    a_ctl_forward: assert property (mem_hit && !mem_addr_i[11] |=> s_ctl_fwd)
        else $error("control space access not forwarded");
    a_ctl_function: assert property (mem_hit && !mem_addr_i[11]
        && sock_a_base_i != sock_b_base_i
        |=> sock_ctl_func_o == $past(mem_addr_i[31:12] == sock_b_base_i))
        else $error("forward names wrong function");
    a_upper_ignored: assert property (mem_hit && mem_addr_i[11:0] > LSR_ALIAS_LAST
        |=> !rd_valid_o && !sock_ctl_valid_o)
        else $error("access above alias answered");
    a_io_miss_zero: assert property (io_win_hit_o[1:0] == 2'b00
        |-> card_io_addr_o[15:0] == 16'h0000)
        else $error("card io address without hit");
    a_mem_page_pass: assert property (mem_win_hit_o[9:5] != 5'h00
        |-> card_mem_addr_o[37:26] == $past(host_mem_addr_i[11:0]))
        else $error("bits below page altered");
endmodule
bind lsr_access lsr_access_props lsr_access_props_i (.*);

// [bench/lsr_host_model.sv]
// Purpose: Host side issuing legacy I/O and memory alias byte accesses
// Assumes: One-cycle strobes, no wait states
// Notes: Idle address and data lines show the inverse of the last value so stale data is never read
`timescale 1ns/1ps
module lsr_host_model (
    // Clock
    input wire logic clk_i,
    // Host requests
    output logic io_valid_o, io_write_o, mem_valid_o, mem_write_o,
    output logic [15:0] io_addr_o,
    output logic [31:0] mem_addr_o,
    output logic [7:0] wdata_o
);
    initial begin
        io_valid_o = 1'b0;
        mem_valid_o = 1'b0;
        io_write_o = 1'b0;
        mem_write_o = 1'b0;
        io_addr_o = 16'h0000;
        mem_addr_o = 32'h0000_0000;
        wdata_o = 8'h00;
    end
    task automatic access(input logic mem, input logic wr, input logic [31:0] a,
        input logic [7:0] d);
        @(negedge clk_i);
        io_valid_o <= !mem;
        mem_valid_o <= mem;
        io_write_o <= wr;
        mem_write_o <= wr;
        io_addr_o <= a[15:0];
        mem_addr_o <= a;
        wdata_o <= d;
        @(negedge clk_i);
        io_valid_o <= 1'b0;
        mem_valid_o <= 1'b0;
        io_addr_o <= ~a[15:0];
        mem_addr_o <= ~a;
        wdata_o <= ~d;
    endtask
endmodule

// [bench/testbench.sv]
// Purpose: Self-checking bench for the legacy socket register access block
// Assumes: Read answers arrive in request order
// Notes: Bases and window settings are fixed; other register data is random
`timescale 1ns/1ps
module testbench;
    localparam logic [15:0] BASE = 16'h03E0;
    localparam logic [19:0] BA = 20'hA_0001;
    localparam logic [19:0] BB = 20'hB_0002;
    logic clk_i = 1'b0, reset_n_i = 1'b0, bus_rst_n = 1'b1, pe_en = 1'b0, h;
    logic io_v, io_w, mem_v, mem_w, rd_v, c_v, c_w, c_f;
    logic [15:0] io_a, host_io = 16'h0000;
    logic [31:0] mem_a, card_io;
    logic [7:0] wd, rd_d, c_d, va, vb;
    logic [10:0] c_a;
    logic [23:0] host_mem = 24'h00_0000;
    logic [3:0] io_hit;
    logic [9:0] mem_hit;
    logic [51:0] card_mem;
    logic [7:0] exp_q[$];
    logic [15:0] cfg[14] = '{16'h0800, 16'h0901, 16'h0AFF, 16'h0B01, 16'h3610, 16'h3700,
        16'h0640, 16'h7010, 16'h7100, 16'h7210, 16'h7300, 16'h7402, 16'h7500, 16'h4610};
    logic [15:0] io_t[4] = '{16'h00FF, 16'h0100, 16'h01FF, 16'h0200};
    logic [23:0] mem_t[4] = '{24'h00_FFFF, 24'h01_0000, 24'h01_0FFF, 24'h01_1000};
    int mismatches = 0, n_tests = 0;
    initial forever #5 clk_i = ~clk_i;
    lsr_access lsr_access_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .pci_bus_reset_n_i(bus_rst_n),
        .power_event_signal_en_i(pe_en), .io_base_i(BASE), .io_valid_i(io_v), .io_write_i(io_w),
        .io_addr_i(io_a), .io_wdata_i(wd), .sock_a_base_i(BA), .sock_b_base_i(BB),
        .mem_valid_i(mem_v), .mem_write_i(mem_w), .mem_addr_i(mem_a), .mem_wdata_i(wd),
        .rd_valid_o(rd_v), .rd_data_o(rd_d), .sock_ctl_valid_o(c_v), .sock_ctl_write_o(c_w),
        .sock_ctl_func_o(c_f), .sock_ctl_addr_o(c_a), .sock_ctl_wdata_o(c_d),
        .host_io_addr_i(host_io), .host_mem_addr_i(host_mem), .io_win_hit_o(io_hit),
        .card_io_addr_o(card_io), .mem_win_hit_o(mem_hit), .card_mem_addr_o(card_mem));
    lsr_host_model lsr_host_model_i (.clk_i(clk_i), .io_valid_o(io_v), .io_write_o(io_w),
        .mem_valid_o(mem_v), .mem_write_o(mem_w), .io_addr_o(io_a), .mem_addr_o(mem_a),
        .wdata_o(wd));
    task automatic chk(input string nm, input logic [51:0] e, input logic [51:0] g);
        n_tests++;
        if (e !== g) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test;
        chk("queue_left", 52'h0, exp_q.size());
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Answers are settled by the falling edge
    always @(negedge clk_i) begin
        if (rd_v === 1'b1) begin
            if (exp_q.size() == 0) chk("rd_extra", 52'h0, 52'h1);
            else chk("rd_data", exp_q.pop_front(), rd_d);
        end
    end
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        lsr_host_model_i.access(1'b0, 1'b1, {16'h0000, BASE}, idx);
        lsr_host_model_i.access(1'b0, 1'b1, {16'h0000, BASE + 16'h0001}, d);
    endtask
    task automatic reg_rd(input logic [7:0] idx, input logic [7:0] e);
        lsr_host_model_i.access(1'b0, 1'b1, {16'h0000, BASE}, idx);
        exp_q.push_back(e);
        lsr_host_model_i.access(1'b0, 1'b0, {16'h0000, BASE + 16'h0001}, 8'h00);
    endtask
    task automatic mem_rd(input logic [19:0] b, input logic [11:0] o, input logic [7:0] e);
        exp_q.push_back(e);
        lsr_host_model_i.access(1'b1, 1'b0, {b, o}, 8'h00);
    endtask
    task automatic bus_reset(input logic pe);
        pe_en = pe;
        bus_rst_n = 1'b0;
        repeat (2) @(negedge clk_i);
        bus_rst_n = 1'b1;
    endtask
    initial begin
        void'($urandom(41926));
        va = $urandom | 8'h01;
        vb = $urandom | 8'h80;
        repeat (5) @(negedge clk_i);
        reset_n_i = 1'b1;
        reg_wr(8'h05, va);
        reg_wr(8'h45, vb);
        reg_rd(8'h05, va);
        reg_rd(8'h45, vb);
        reg_rd(8'h85, 8'h00);
        exp_q.push_back(8'h85);
        lsr_host_model_i.access(1'b0, 1'b0, {16'h0000, BASE}, 8'h00);
        mem_rd(BA, 12'h805, va);
        mem_rd(BB, 12'h805, vb);
        mem_rd(BA, 12'h840, 8'h00);
        lsr_host_model_i.access(1'b1, 1'b1, {BA, 12'h803}, vb);
        reg_rd(8'h03, vb);
        lsr_host_model_i.access(1'b1, 1'b0, {BA, 12'h900}, 8'h00);
        lsr_host_model_i.access(1'b1, 1'b1, {BB, 12'h7FF}, va);
        chk("sock_ctl", {3'b111, 11'h7FF, va}, {c_v, c_w, c_f, c_a, c_d});
        foreach (cfg[i]) reg_wr(cfg[i][15:8], cfg[i][7:0]);
        for (int i = 0; i < 4; i++) begin
            h = (i == 1 || i == 2);
            host_io = io_t[i];
            host_mem = mem_t[i];
            @(negedge clk_i);
            chk("io_hit", {3'b000, h}, io_hit);
            chk("card_io", h ? io_t[i] + 16'h0010 : 16'h0000, card_io[15:0]);
            chk("mem_hit", {h, 9'h000}, mem_hit);
            chk("card_io_b", 16'h0000, card_io[31:16]);
            chk("card_mem_a", 26'h0, card_mem[25:0]);
            chk("card_mem", h ? {mem_t[i][23:12] + 14'h0002, mem_t[i][11:0]} : 26'h0,
                card_mem[51:26]);
        end
        reg_wr(8'h16, va);
        reg_wr(8'h04, vb);
        reg_wr(8'h07, va);
        bus_reset(1'b1);
        reg_rd(8'h16, va);
        reg_rd(8'h04, vb);
        reg_rd(8'h07, 8'h00);
        bus_reset(1'b0);
        reg_rd(8'h04, 8'h00);
        reset_n_i = 1'b0;
        repeat (2) @(negedge clk_i);
        reset_n_i = 1'b1;
        reg_rd(8'h16, 8'h00);
        repeat (3) @(negedge clk_i);
        finish_test();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        finish_test();
    end
endmodule

// [hw/lsr_access.sv]
// Purpose: Host access front end and window translation for legacy socket registers
// Assumes: One access per cycle; I/O base and memory bases come from config space
// Notes: Read data is returned one cycle after the request
//        A register write shows in window translation two cycles later
//        Equal function bases write both slices; function 1 takes reads and forwards
//        A write during bus reset to a non-retained register is lost
//        Socket control space is forwarded out, not stored here
//        Bus reset clears the index register as well
//
// Overview of operation
// - Host writes register index at I/O base, then accesses data at base plus one.
// - Index/data pair decoded at the single legacy base shared by both sockets.
// - Index 00h-3Fh reaches socket A, index 40h-7Fh reaches socket B.
// - Memory alias of the registers starts at 800h in the socket window.
// - Each function has its own window base; alias range 800h-844h in both.
// - Socket control registers decode from offset zero of the same 4K window.
// - Interrupt registers at alias 803h and 805h must be reachable.
// - Each socket provides two I/O windows with start, end and offset.
// - I/O window start and end compare at byte granularity.
// - Each socket provides five memory windows with start, end and offset.
// - Memory windows work on 4K pages; lower address bits ignored in matching.
// - Context-retaining bits ignore bus reset and clear only on global reset.
// - Interrupt/status bits ignore bus reset while power-event signalling is enabled.

`timescale 1ns/1ps

module lsr_access
    import lsr_pkg::*;
#(
    parameter int NUM_SOCK = 2,
    parameter int NUM_IO_WIN = 2,
    parameter int NUM_MEM_WIN = 5,
    parameter logic [63:0] CTX_REG_MASK = LSR_CTX_REGS
) (
    // Clock and resets
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic pci_bus_reset_n_i,
    input wire logic power_event_signal_en_i,

    // Legacy I/O index/data access
    input wire logic [15:0] io_base_i,
    input wire logic io_valid_i,
    input wire logic io_write_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,

    // Memory alias access
    input wire logic [19:0] sock_a_base_i,
    input wire logic [19:0] sock_b_base_i,
    input wire logic mem_valid_i,
    input wire logic mem_write_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [7:0] mem_wdata_i,

    // Read answer
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,

    // Socket control register access forwarded out
    output logic sock_ctl_valid_o,
    output logic sock_ctl_write_o,
    output logic sock_ctl_func_o,
    output logic [10:0] sock_ctl_addr_o,
    output logic [7:0] sock_ctl_wdata_o,

    // Window translation
    input wire logic [15:0] host_io_addr_i,
    input wire logic [23:0] host_mem_addr_i,
    output logic [NUM_SOCK*NUM_IO_WIN-1:0] io_win_hit_o,
    output logic [NUM_SOCK*16-1:0] card_io_addr_o,
    output logic [NUM_SOCK*NUM_MEM_WIN-1:0] mem_win_hit_o,
    output logic [NUM_SOCK*26-1:0] card_mem_addr_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NUM_SOCK-1:0][63:0][7:0] regs;
        logic [7:0] index;
        logic rd_valid;
        logic [7:0] rd_data;
        logic ctl_valid;
        logic ctl_write;
        logic ctl_func;
        logic [10:0] ctl_addr;
        logic [7:0] ctl_wdata;
        logic [NUM_SOCK*NUM_IO_WIN-1:0] io_hit;
        logic [NUM_SOCK*16-1:0] card_io;
        logic [NUM_SOCK*NUM_MEM_WIN-1:0] mem_hit;
        logic [NUM_SOCK*26-1:0] card_mem;
    } lsr_state_s;

    lsr_state_s st;
    lsr_state_s next_st;

    // ----------------------------------------------------------------
    // Function window bases
    // ----------------------------------------------------------------
    // Function 0 maps to socket A, function 1 to socket B
    logic [1:0][19:0] func_base;
    assign func_base[0] = sock_a_base_i;
    assign func_base[1] = sock_b_base_i;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [11:0] ofs;
        logic [15:0] io_start;
        logic [15:0] io_end;
        logic [15:0] io_ofs;
        logic [11:0] pg;
        logic [11:0] m_start;
        logic [11:0] m_end;
        logic [13:0] m_ofs;
        logic [5:0] b;
        logic keep;
        logic io_en;
        logic m_en;
        logic sock_sel;

        ofs = 12'h000;
        io_start = 16'h0000;
        io_end = 16'h0000;
        io_ofs = 16'h0000;
        pg = host_mem_addr_i[23:LSR_WIN_BITS];
        m_start = 12'h000;
        m_end = 12'h000;
        m_ofs = 14'h0000;
        b = 6'h00;
        keep = 1'b0;
        io_en = 1'b0;
        m_en = 1'b0;
        sock_sel = 1'b0;

        next_st = st;
        next_st.rd_valid = 1'b0;
        next_st.ctl_valid = 1'b0;

        // ----------------------------------------------------------------
        // Host access decode
        // ----------------------------------------------------------------
        // One access per cycle: I/O wins, a clashing memory access is dropped
        if (io_valid_i) begin
            if (io_addr_i == io_base_i) begin
                if (io_write_i) begin
                    next_st.index = io_wdata_i;
                end else begin
                    next_st.rd_valid = 1'b1;
                    next_st.rd_data = st.index;
                end
            end else if (io_addr_i == 16'(io_base_i + LSR_DATA_PORT_OFS)) begin
                next_st.rd_valid = !io_write_i;
                next_st.rd_data = 8'h00;
                // Index above both slices reads zero and drops writes
                sock_sel = st.index >= LSR_SOCK_B_FIRST;
                if (st.index <= LSR_INDEX_LAST) begin
                    if (io_write_i) begin
                        next_st.regs[sock_sel][st.index[5:0]] = io_wdata_i;
                    end else begin
                        next_st.rd_data = st.regs[sock_sel][st.index[5:0]];
                    end
                end
            end
        end else if (mem_valid_i) begin
            // ------------------------------------------------------------
            // Memory alias decode
            // ------------------------------------------------------------
            // Both passes run; equal bases leave function 1 holding the result
            for (int f = 0; f < NUM_SOCK; f++) begin
                if (mem_addr_i[31:LSR_WIN_BITS] == func_base[f]) begin
                    ofs = mem_addr_i[LSR_WIN_BITS-1:0];
                    if (ofs >= LSR_ALIAS_FIRST && ofs <= LSR_ALIAS_REGS_LAST) begin
                        if (mem_write_i) begin
                            next_st.regs[f][ofs[5:0]] = mem_wdata_i;
                        end else begin
                            next_st.rd_valid = 1'b1;
                            next_st.rd_data = st.regs[f][ofs[5:0]];
                        end
                    end else if (ofs > LSR_ALIAS_REGS_LAST && ofs <= LSR_ALIAS_LAST) begin
                        next_st.rd_valid = !mem_write_i;
                        next_st.rd_data = 8'h00;
                    end else if (ofs >= LSR_SOCK_CTL_FIRST && ofs < LSR_ALIAS_FIRST) begin
                        next_st.ctl_valid = 1'b1;
                        next_st.ctl_write = mem_write_i;
                        next_st.ctl_func = 1'(f);
                        next_st.ctl_addr = ofs[10:0];
                        next_st.ctl_wdata = mem_wdata_i;
                    end
                end
            end
        end

        // ----------------------------------------------------------------
        // Window translation
        // ----------------------------------------------------------------
        // Translation uses settled registers, so a write shows two cycles later
        // Overlapping windows: the highest hitting window sets the card address
        for (int s = 0; s < NUM_SOCK; s++) begin
            next_st.card_io[s*16 +: 16] = 16'h0000;
            next_st.card_mem[s*26 +: 26] = 26'h000_0000;
            for (int n = 0; n < NUM_IO_WIN; n++) begin
                b = 6'(LSR_REG_IO_WIN0 + LSR_IO_WIN_STRIDE * n);
                io_start = {st.regs[s][b + 6'd1], st.regs[s][b]};
                io_end = {st.regs[s][b + 6'd3], st.regs[s][b + 6'd2]};
                b = 6'(LSR_REG_IO_OFS0 + 2 * n);
                io_ofs = {st.regs[s][b + 6'd1], st.regs[s][b]};
                io_en = st.regs[s][LSR_REG_WIN_ENABLE][LSR_IO_EN_BIT + n];

                next_st.io_hit[s*NUM_IO_WIN + n] =
                    io_en && host_io_addr_i >= io_start && host_io_addr_i <= io_end;
                if (next_st.io_hit[s*NUM_IO_WIN + n]) begin
                    next_st.card_io[s*16 +: 16] = 16'(host_io_addr_i + io_ofs);
                end
            end

            for (int n = 0; n < NUM_MEM_WIN; n++) begin
                b = 6'(LSR_REG_MEM_WIN0 + LSR_MEM_WIN_STRIDE * n);
                m_start = {st.regs[s][b + 6'd1][3:0], st.regs[s][b]};
                m_end = {st.regs[s][b + 6'd3][3:0], st.regs[s][b + 6'd2]};
                m_ofs = {st.regs[s][b + 6'd5][5:0], st.regs[s][b + 6'd4]};
                m_en = st.regs[s][LSR_REG_WIN_ENABLE][n];

                next_st.mem_hit[s*NUM_MEM_WIN + n] =
                    m_en && pg >= m_start && pg <= m_end;
                if (next_st.mem_hit[s*NUM_MEM_WIN + n]) begin
                    // Bits below a page pass through unchanged
                    // page offset add
                    next_st.card_mem[s*26 +: 26] =
                        {14'({2'b00, pg} + m_ofs), host_mem_addr_i[LSR_WIN_BITS-1:0]};
                end
            end
        end

        // ----------------------------------------------------------------
        // Reset handling
        // ----------------------------------------------------------------
        // Bus reset spares retained registers so context survives D3 to D0
        if (!pci_bus_reset_n_i) begin
            next_st.index = 8'h00;
            next_st.rd_valid = 1'b0;
            next_st.ctl_valid = 1'b0;

            for (int s = 0; s < NUM_SOCK; s++) begin
                for (int i = 0; i < 64; i++) begin
                    keep = CTX_REG_MASK[i]
                        || (LSR_PME_HELD_REGS[i] && power_event_signal_en_i);
                    if (!keep) begin
                        next_st.regs[s][i] = LSR_RESET_VALUE;
                    end
                end
            end
        end

        // Global reset comes last so it overrides the bus reset
        // global reset clears all
        if (!reset_n_i) begin
            next_st = '0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Reset is folded into next_st, so this process only registers it
    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rd_valid_o = st.rd_valid;
    assign rd_data_o = st.rd_data;
    assign sock_ctl_valid_o = st.ctl_valid;
    assign sock_ctl_write_o = st.ctl_write;
    assign sock_ctl_func_o = st.ctl_func;
    assign sock_ctl_addr_o = st.ctl_addr;
    assign sock_ctl_wdata_o = st.ctl_wdata;
    assign io_win_hit_o = st.io_hit;
    assign card_io_addr_o = st.card_io;
    assign mem_win_hit_o = st.mem_hit;
    assign card_mem_addr_o = st.card_mem;

endmodule

// [hw/lsr_pkg.sv]
// Purpose: Constants for the legacy socket register access block
// Assumes: Byte-wide legacy registers, two sockets, 4K memory window per function
// Notes: Offsets are register indices within one socket slice

package lsr_pkg;

    // ----------------------------------------------------------------
    // Index/data and memory alias layout
    // ----------------------------------------------------------------
    localparam logic [15:0] LSR_DATA_PORT_OFS = 16'h0001;
    localparam logic [7:0] LSR_SOCK_B_FIRST = 8'h40;
    localparam logic [7:0] LSR_INDEX_LAST = 8'h7F;
    localparam logic [11:0] LSR_ALIAS_FIRST = 12'h800;
    localparam logic [11:0] LSR_ALIAS_REGS_LAST = 12'h83F;
    localparam logic [11:0] LSR_ALIAS_LAST = 12'h844;
    localparam logic [11:0] LSR_SOCK_CTL_FIRST = 12'h000;
    localparam int LSR_WIN_BITS = 12;

    // ----------------------------------------------------------------
    // Register indices inside one socket slice
    // ----------------------------------------------------------------
    localparam logic [5:0] LSR_REG_WIN_ENABLE = 6'h06;
    localparam logic [5:0] LSR_REG_IO_WIN0 = 6'h08;
    localparam logic [5:0] LSR_REG_MEM_WIN0 = 6'h10;
    localparam logic [5:0] LSR_REG_IO_OFS0 = 6'h36;
    localparam int LSR_IO_WIN_STRIDE = 4;
    localparam int LSR_MEM_WIN_STRIDE = 8;
    localparam int LSR_IO_EN_BIT = 6;

    // ----------------------------------------------------------------
    // Reset behaviour per register (one bit per index)
    // ----------------------------------------------------------------
    localparam logic [63:0] LSR_PME_HELD_REGS = 64'h0000_0000_0000_003C;
    localparam logic [63:0] LSR_CTX_REGS = 64'h0000_0000_0040_0000;
    localparam logic [7:0] LSR_RESET_VALUE = 8'h00;

endpackage
